// file: pkg/csba_pkg.sv
/*
  Constants for the cpu status and bank addressing block: AHB-Lite
  register offsets, program status field layout, address map figures.
  Assumes a 32-bit AHB-Lite bus with word-aligned registers.
*/
//
// Contract
// RQ1 - one linear 64 Kbyte address space
// RQ2 - 16-bit program counter
// RQ3 - 16-bit accumulator, 8-bit ops use low byte
// RQ4 - 16-bit temporary accumulator as second operand
// RQ5 - index, extra and stack pointers, 16 bits
// RQ6 - status upper byte pointers, lower byte flags
// RQ7 - direct 0x80-0xFF remapped by direct bank pointer; code leaves them unmapped when the pointer is 0
// RQ8 - direct 0x00-0x7F never remapped
// RQ9 - half carry from bit 3 to 4
// RQ10 - interrupt enable flag, cleared at reset
// RQ11 - admit interrupt only above current level
// RQ12 - negative flag follows result msb
// RQ13 - zero flag on zero result
// RQ14 - overflow flag on two's-complement overflow
// RQ15 - carry from bit 7, shift loads out bit
// RQ16 - 32 banks of eight 8-bit registers
// RQ17 - bank pointer and opcode low bits select register
// RQ18 - register address 0x100 + 8*bank + index
// RQ19 - bank pointer five bits, direct pointer three
package csba_pkg;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 16;
  // register byte offsets on the bus
  localparam logic [7:0] OFS_PC = 8'h00;
  localparam logic [7:0] OFS_ACC = 8'h04;
  localparam logic [7:0] OFS_TMP = 8'h08;
  localparam logic [7:0] OFS_IDX = 8'h0C;
  localparam logic [7:0] OFS_EXT = 8'h10;
  localparam logic [7:0] OFS_SP = 8'h14;
  localparam logic [7:0] OFS_PS = 8'h18;
  localparam logic [7:0] OFS_ALU = 8'h1C;
  localparam logic [7:0] OFS_DIR = 8'h20;
  localparam logic [7:0] OFS_GPR = 8'h24;
  localparam logic [7:0] OFS_IRQ = 8'h28;
  localparam logic [7:0] OFS_ID = 8'h2C;
  // arbitrary identification value
  localparam logic [31:0] ID_VALUE = 32'h0000_C5BA;
  // program status fields
  localparam int unsigned PS_RP_LSB = 11;
  localparam int unsigned PS_DP_LSB = 8;
  localparam int unsigned CC_H = 7;
  localparam int unsigned CC_I = 6;
  localparam int unsigned CC_IL_LSB = 4;
  localparam int unsigned CC_N = 3;
  localparam int unsigned CC_Z = 2;
  localparam int unsigned CC_V = 1;
  localparam int unsigned CC_C = 0;
  localparam logic [15:0] PS_RESET = 16'h0030;
  // address map
  localparam logic [15:0] BANK_BASE = 16'h0100;
  localparam logic [15:0] DIR_WIN_BASE = 16'h0080;
  localparam logic [15:0] DIR_MAP_BASE = 16'h0100;
  // alu operations
  localparam logic [2:0] OP_ADD = 3'h0;
  localparam logic [2:0] OP_SUB = 3'h1;
  localparam logic [2:0] OP_SHL = 3'h2;
  localparam logic [2:0] OP_SHR = 3'h3;
  typedef enum logic [1:0] {
    CSBA_IDLE = 2'b01,
    CSBA_DATA = 2'b10
  } csba_phase_t;
endpackage

// file: src/csba_core.sv
/*
  Dedicated cpu registers, program status with flags, 8-bit alu flag
  logic, direct bank remap and general register address generation.
  Assumes a single AHB-Lite master; zero wait states, OKAY always.
*/
`timescale 1ns/100ps
module csba_core (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // address and interrupt results
  output logic [csba_pkg::ADDR_W-1:0] direct_phys_addr,
  output logic [csba_pkg::ADDR_W-1:0] gpr_phys_addr,
  output logic irq_accept
);
  import csba_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // functions
  // direct address remap: low half fixed, high half by a nonzero bank pointer
  function automatic logic [15:0] remap(input logic [7:0] dir,
                                        input logic [2:0] dp);
    logic [15:0] r;
    r = {8'h00, dir};
    if (dir[7] && dp != 3'h0) begin // RQ7
      r = DIR_MAP_BASE + {6'h00, dp - 3'h1, 7'h00} + {9'h000, dir[6:0]};
    end
    return r; // RQ8
  endfunction

  // general register byte address in the bank area
  function automatic logic [15:0] gpr_addr(input logic [4:0] rp,
                                           input logic [2:0] idx);
    return BANK_BASE + {8'h00, rp, idx}; // RQ18 RQ17 RQ16
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // registers
  logic [15:0] program_counter; // RQ2
  logic [15:0] accumulator; // RQ3
  logic [15:0] temporary_accumulator; // RQ4
  logic [15:0] index_pointer; // RQ5
  logic [15:0] extra_pointer;
  logic [15:0] stack_pointer;
  logic [15:0] program_status; // RQ6
  logic [7:0] dir_addr;
  logic [2:0] gpr_index;
  logic [1:0] irq_level;
  logic irq_req;
  csba_phase_t phase;
  logic [7:0] addr_q;
  logic write_q;

  ////////////////////////////////////////////////////////////////////////
  // status fields
  wire [4:0] register_bank_pointer = program_status[15:PS_RP_LSB]; // RQ19
  wire [2:0] direct_bank_pointer = program_status[PS_RP_LSB-1:PS_DP_LSB];
  wire [1:0] current_interrupt_level = program_status[CC_I-1:CC_IL_LSB];
  wire irq_enable = program_status[CC_I];

  ////////////////////////////////////////////////////////////////////////
  // bus decode
  wire take = hsel && hready && htrans[1];
  wire wr_hit = (phase == CSBA_DATA) && write_q;
  wire [2:0] alu_op = hwdata[2:0];

  ////////////////////////////////////////////////////////////////////////
  // 8-bit alu on low bytes of accumulator and temporary accumulator
  wire [7:0] a8 = accumulator[7:0];
  wire [7:0] t8 = temporary_accumulator[7:0];
  wire is_sub = (alu_op == OP_SUB);
  wire [7:0] t_eff = is_sub ? ~t8 : t8;
  wire [4:0] lo_sum = {1'b0, a8[3:0]} + {1'b0, t_eff[3:0]} +
                      {4'h0, is_sub};
  wire [8:0] full_sum = {1'b0, a8} + {1'b0, t_eff} + {8'h00, is_sub};
  // borrow is the inverted carry of the complement add
  wire half_c = lo_sum[4] ^ is_sub; // RQ9
  wire add_c = full_sum[8] ^ is_sub; // RQ15
  wire add_v = (a8[7] == t_eff[7]) && (full_sum[7] != a8[7]); // RQ14
  wire [7:0] shl_r = {a8[6:0], 1'b0};
  wire [7:0] shr_r = {1'b0, a8[7:1]};
  wire is_shift = (alu_op == OP_SHL) || (alu_op == OP_SHR);
  wire [7:0] alu_res = (alu_op == OP_SHL) ? shl_r :
                       (alu_op == OP_SHR) ? shr_r : full_sum[7:0];
  wire alu_carry = (alu_op == OP_SHL) ? a8[7] :
                   (alu_op == OP_SHR) ? a8[0] : add_c; // RQ15
  // shifts keep half carry and overflow unchanged
  wire [7:0] next_cc = {is_shift ? program_status[CC_H] : half_c,
                        program_status[CC_I:CC_IL_LSB],
                        alu_res[7], // RQ12
                        alu_res == 8'h00, // RQ13
                        is_shift ? program_status[CC_V] : add_v,
                        alu_carry};

  ////////////////////////////////////////////////////////////////////////
  // interrupt admission: lower number is higher priority
  wire next_accept = irq_req && irq_enable &&
                     (irq_level < current_interrupt_level); // RQ10 RQ11

  ////////////////////////////////////////////////////////////////////////
  // read mux decodes the address phase, so the data stands in the data
  // phase; decoding the latched address would hand back the last read
  wire [7:0] rd_ofs = haddr[7:0];
  wire [31:0] rd_mux =
    (rd_ofs == OFS_PC) ? {16'h0000, program_counter} :
    (rd_ofs == OFS_ACC) ? {16'h0000, accumulator} :
    (rd_ofs == OFS_TMP) ? {16'h0000, temporary_accumulator} :
    (rd_ofs == OFS_IDX) ? {16'h0000, index_pointer} :
    (rd_ofs == OFS_EXT) ? {16'h0000, extra_pointer} :
    (rd_ofs == OFS_SP) ? {16'h0000, stack_pointer} :
    (rd_ofs == OFS_PS) ? {16'h0000, program_status} :
    (rd_ofs == OFS_DIR) ? {24'h000000, dir_addr} :
    (rd_ofs == OFS_GPR) ? {29'h00000000, gpr_index} :
    (rd_ofs == OFS_IRQ) ? {29'h00000000, irq_req, irq_level} :
    (rd_ofs == OFS_ID) ? ID_VALUE : 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////
  // bus phase tracking; address held for the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase <= CSBA_IDLE;
      addr_q <= 8'h00;
      write_q <= 1'b0;
    end else begin
      phase <= take ? CSBA_DATA : CSBA_IDLE;
      if (take) begin
        addr_q <= haddr[7:0];
        write_q <= hwrite;
      end
    end
  end

  // read data registered at address phase so hrdata comes from a flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      // a write landing at this same edge is not yet seen by the read
      if (take) hrdata <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pointer registers, full 16-bit writes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      program_counter <= 16'h0000;
      index_pointer <= 16'h0000;
      extra_pointer <= 16'h0000;
      stack_pointer <= 16'h0000;
    end else if (wr_hit) begin
      if (addr_q == OFS_PC) program_counter <= hwdata[15:0]; // RQ2
      if (addr_q == OFS_IDX) index_pointer <= hwdata[15:0]; // RQ5
      if (addr_q == OFS_EXT) extra_pointer <= hwdata[15:0];
      if (addr_q == OFS_SP) stack_pointer <= hwdata[15:0];
    end
  end

  // accumulators; an alu command writes only the low byte
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      accumulator <= 16'h0000;
      temporary_accumulator <= 16'h0000;
    end else if (wr_hit) begin
      if (addr_q == OFS_ACC) accumulator <= hwdata[15:0];
      if (addr_q == OFS_TMP) temporary_accumulator <= hwdata[15:0];
      if (addr_q == OFS_ALU) accumulator[7:0] <= alu_res; // RQ3 RQ4
    end
  end

  // program status: direct write, or flag update by the alu
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      program_status <= PS_RESET; // RQ10
    end else if (wr_hit && addr_q == OFS_PS) begin
      program_status <= hwdata[15:0];
    end else if (wr_hit && addr_q == OFS_ALU) begin
      program_status[7:0] <= next_cc; // RQ6
    end
  end

  // address request registers and interrupt request
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dir_addr <= 8'h00;
      gpr_index <= 3'h0;
      irq_level <= 2'h3;
      irq_req <= 1'b0;
    end else if (wr_hit) begin
      if (addr_q == OFS_DIR) dir_addr <= hwdata[7:0];
      if (addr_q == OFS_GPR) gpr_index <= hwdata[2:0]; // RQ17
      if (addr_q == OFS_IRQ) begin
        irq_level <= hwdata[1:0];
        irq_req <= hwdata[2];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // address outputs, one flop after the inputs settle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      direct_phys_addr <= 16'h0000;
      gpr_phys_addr <= BANK_BASE;
      irq_accept <= 1'b0;
    end else begin
      direct_phys_addr <= remap(dir_addr, direct_bank_pointer); // RQ1
      gpr_phys_addr <= gpr_addr(register_bank_pointer, gpr_index);
      irq_accept <= next_accept; // RQ11
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  // address generation; the outputs trail their inputs by one edge,
  // so each input-based expectation is built from the previous cycle's values
  chk_low_direct_fixed: assert property (@(posedge hclk) // RQ8
    disable iff (!hresetn) !$past(dir_addr[7]) |->
    direct_phys_addr == {8'h00, $past(dir_addr)})
    else $error("low direct address was remapped");
  chk_high_direct_map: assert property (@(posedge hclk) // RQ7
    disable iff (!hresetn)
    ($past(dir_addr[7]) && $past(direct_bank_pointer) != 3'h0) |->
    direct_phys_addr[6:0] == $past(dir_addr[6:0]) &&
    direct_phys_addr[15:7] == 9'h001 + {6'h00, $past(direct_bank_pointer)})
    else $error("direct bank window wrong");
  chk_dp_zero_plain: assert property (@(posedge hclk) // RQ7
    disable iff (!hresetn)
    ($past(dir_addr[7]) && $past(direct_bank_pointer) == 3'h0) |->
    direct_phys_addr == {8'h00, $past(dir_addr)})
    else $error("unmapped direct address was moved");
  chk_direct_in_map: assert property (@(posedge hclk) // RQ1
    disable iff (!hresetn) direct_phys_addr[15:11] == 5'h00)
    else $error("direct address left the mapped area");
  chk_gpr_address: assert property (@(posedge hclk) // RQ18
    disable iff (!hresetn) gpr_phys_addr == 16'h0100 +
    {8'h00, $past(register_bank_pointer), $past(gpr_index)})
    else $error("register bank address wrong");
  chk_gpr_in_banks: assert property (@(posedge hclk) // RQ16
    disable iff (!hresetn) gpr_phys_addr[15:8] == 8'h01)
    else $error("register address outside the bank area");

  // interrupt admission, both directions
  chk_irq_blocked: assert property (@(posedge hclk) // RQ10
    disable iff (!hresetn) !$past(irq_enable) |-> !irq_accept)
    else $error("interrupt accepted while disabled");
  chk_irq_level: assert property (@(posedge hclk) // RQ11
    disable iff (!hresetn) irq_accept |->
    $past(irq_level) < $past(current_interrupt_level))
    else $error("interrupt accepted at too low priority");
  chk_irq_admit: assert property (@(posedge hclk) // RQ11
    disable iff (!hresetn) (irq_req && irq_enable &&
    irq_level < current_interrupt_level) |=> irq_accept)
    else $error("admissible interrupt was refused");

  // alu command: flags, result byte and what it must leave alone
  wire alu_hit = wr_hit && (addr_q == OFS_ALU);
  chk_zero_flag: assert property (@(posedge hclk) // RQ13
    disable iff (!hresetn) alu_hit |=>
    program_status[CC_Z] == (accumulator[7:0] == 8'h00))
    else $error("zero flag disagrees with result");
  chk_neg_flag: assert property (@(posedge hclk) // RQ12
    disable iff (!hresetn) alu_hit |=>
    program_status[CC_N] == accumulator[7])
    else $error("negative flag disagrees with result");
  chk_add_carry: assert property (@(posedge hclk) // RQ15
    disable iff (!hresetn) (alu_hit && alu_op == OP_ADD) |=>
    program_status[CC_C] ==
    (({1'b0, $past(a8)} + {1'b0, $past(t8)}) > 9'h0FF))
    else $error("carry flag wrong after add");
  chk_half_carry: assert property (@(posedge hclk) // RQ9
    disable iff (!hresetn) (alu_hit && alu_op == OP_ADD) |=>
    program_status[CC_H] ==
    (({1'b0, $past(a8[3:0])} + {1'b0, $past(t8[3:0])}) > 5'h0F))
    else $error("half carry wrong after add");
  chk_overflow: assert property (@(posedge hclk) // RQ14
    disable iff (!hresetn) (alu_hit && alu_op == OP_ADD) |=>
    program_status[CC_V] == ($past(a8[7]) == $past(t8[7]) &&
    accumulator[7] != $past(a8[7])))
    else $error("overflow flag wrong after add");
  chk_sub_carry: assert property (@(posedge hclk) // RQ15
    disable iff (!hresetn) (alu_hit && alu_op == OP_SUB) |=>
    program_status[CC_C] == ($past(a8) < $past(t8)))
    else $error("borrow flag wrong after subtract");
  chk_sub_half: assert property (@(posedge hclk) // RQ9
    disable iff (!hresetn) (alu_hit && alu_op == OP_SUB) |=>
    program_status[CC_H] == ($past(a8[3:0]) < $past(t8[3:0])))
    else $error("half borrow wrong after subtract");
  chk_sub_overflow: assert property (@(posedge hclk) // RQ14
    disable iff (!hresetn) (alu_hit && alu_op == OP_SUB) |=>
    program_status[CC_V] == ($past(a8[7]) != $past(t8[7]) &&
    accumulator[7] != $past(a8[7])))
    else $error("overflow flag wrong after subtract");
  chk_shift_carry: assert property (@(posedge hclk) // RQ15
    disable iff (!hresetn) (alu_hit && alu_op == OP_SHR) |=>
    program_status[CC_C] == $past(a8[0]))
    else $error("shift carry is not the bit shifted out");
  chk_shl_carry: assert property (@(posedge hclk) // RQ15
    disable iff (!hresetn) (alu_hit && alu_op == OP_SHL) |=>
    program_status[CC_C] == $past(a8[7]))
    else $error("left shift carry is not the bit shifted out");
  chk_shift_keeps_hv: assert property (@(posedge hclk) // RQ9
    disable iff (!hresetn)
    (alu_hit && (alu_op == OP_SHL || alu_op == OP_SHR)) |=>
    program_status[CC_H] == $past(program_status[CC_H]) &&
    program_status[CC_V] == $past(program_status[CC_V]))
    else $error("shift disturbed half carry or overflow");
  chk_add_result: assert property (@(posedge hclk) // RQ4
    disable iff (!hresetn) (alu_hit && alu_op == OP_ADD) |=>
    accumulator[7:0] == 8'($past(a8) + $past(t8)))
    else $error("add result byte wrong");
  chk_alu_high_byte: assert property (@(posedge hclk) // RQ3
    disable iff (!hresetn) alu_hit |=>
    accumulator[15:8] == $past(accumulator[15:8]))
    else $error("byte operation touched the upper accumulator");
  chk_tmp_kept: assert property (@(posedge hclk) // RQ4
    disable iff (!hresetn) alu_hit |=>
    temporary_accumulator == $past(temporary_accumulator))
    else $error("byte operation changed the second operand");
  chk_status_upper_kept: assert property (@(posedge hclk) // RQ6
    disable iff (!hresetn) alu_hit |=>
    program_status[15:8] == $past(program_status[15:8]))
    else $error("byte operation changed the bank pointers");
  chk_ie_level_kept: assert property (@(posedge hclk) // RQ10
    disable iff (!hresetn) alu_hit |=>
    program_status[CC_I:CC_IL_LSB] == $past(program_status[CC_I:CC_IL_LSB]))
    else $error("byte operation changed interrupt control");

  // register writes land at the end of the data phase; reads of the
  // status word show the value at the address phase
  chk_pc_write: assert property (@(posedge hclk) // RQ2
    disable iff (!hresetn) (wr_hit && addr_q == OFS_PC) |=>
    program_counter == $past(hwdata[15:0]))
    else $error("program counter write lost");
  chk_acc_write: assert property (@(posedge hclk) // RQ3
    disable iff (!hresetn) (wr_hit && addr_q == OFS_ACC) |=>
    accumulator == $past(hwdata[15:0]))
    else $error("accumulator write lost");
  chk_idx_write: assert property (@(posedge hclk) // RQ5
    disable iff (!hresetn) (wr_hit && addr_q == OFS_IDX) |=>
    index_pointer == $past(hwdata[15:0]))
    else $error("index pointer write lost");
  chk_sp_write: assert property (@(posedge hclk) // RQ5
    disable iff (!hresetn) (wr_hit && addr_q == OFS_SP) |=>
    stack_pointer == $past(hwdata[15:0]))
    else $error("stack pointer write lost");
  chk_ps_write: assert property (@(posedge hclk) // RQ6
    disable iff (!hresetn) (wr_hit && addr_q == OFS_PS) |=>
    program_status == $past(hwdata[15:0]))
    else $error("program status write lost");
  chk_ps_readback: assert property (@(posedge hclk) // RQ6
    disable iff (!hresetn) (take && !hwrite && haddr[7:0] == OFS_PS) |=>
    hrdata == {16'h0000, $past(program_status)})
    else $error("program status read data wrong");
endmodule // csba_core

// file: tb/csba_core_test.sv
/*
  Self-checking bench for csba_core: registers over ahb-lite, alu flags,
  direct remap, general register address and interrupt admission.
  Assumes a zero-wait slave whose hreadyout also feeds its hready.
*/
`timescale 1ns/100ps
module csba_core_test;
  import csba_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, irq_accept;
  logic [15:0] direct_phys_addr, gpr_phys_addr;
  logic watch_en = 1'b0;
  logic [1:0] watch_sel = 2'h0;
  logic [31:0] exp_q[$];
  logic [31:0] seed = 32'h49; // lfsr start value 73
  int num_errors = 0;
  int n_tests = 0;

  // free-running 100 MHz clock
  always #5 hclk = ~hclk;

  csba_core csba_core_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp),
    .direct_phys_addr(direct_phys_addr), .gpr_phys_addr(gpr_phys_addr),
    .irq_accept(irq_accept));

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_tests++;
    if (seen !== want) begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, want);
    end
  endtask

  // single transfer; the master holds each phase until hready is seen
  task automatic xfer(input logic wr, input logic [7:0] ofs,
                      input logic [31:0] data);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, ofs};
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= data;
    watch_en <= ~wr;
    watch_sel <= 2'h0;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    watch_en <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] ofs, input logic [31:0] data);
    xfer(1'b1, ofs, data);
  endtask

  task automatic rd(input logic [7:0] ofs, input logic [31:0] want);
    exp_q.push_back(want);
    xfer(1'b0, ofs, 32'h0);
  endtask

  // outputs follow a register change one edge later; margin of two
  task automatic port(input logic [1:0] sel, input logic [31:0] want);
    repeat (2) @(posedge hclk);
    exp_q.push_back(want);
    watch_en <= 1'b1;
    watch_sel <= sel;
    @(posedge hclk);
    watch_en <= 1'b0;
  endtask

  // alu op on low bytes; expected flags built here from the operands
  task automatic alu(input logic [2:0] op, input logic [15:0] a,
                     input logic [15:0] b);
    logic [15:0] p, e;
    logic [8:0] s;
    logic h, v;
    seed = lfsr(seed);
    p = seed[15:0];
    h = p[CC_H];
    v = p[CC_V];
    wr(OFS_PS, {16'h0, p});
    wr(OFS_ACC, {16'h0, a});
    wr(OFS_TMP, {16'h0, b});
    wr(OFS_ALU, {29'h0, op});
    if (op == OP_ADD) begin
      s = {1'b0, a[7:0]} + {1'b0, b[7:0]};
      h = ({1'b0, a[3:0]} + {1'b0, b[3:0]}) > 5'h0F;
      v = (a[7] == b[7]) && (s[7] != a[7]);
    end else if (op == OP_SUB) begin
      s = {1'b0, a[7:0]} - {1'b0, b[7:0]};
      h = a[3:0] < b[3:0];
      v = (a[7] != b[7]) && (s[7] != a[7]);
    end else if (op == OP_SHL) begin
      s = {a[7:0], 1'b0};
    end else begin
      s = {a[0], 1'b0, a[7:1]};
    end
    e = p;
    e[CC_H] = h;
    e[CC_N] = s[7];
    e[CC_Z] = (s[7:0] == 8'h00);
    e[CC_V] = v;
    e[CC_C] = s[8];
    rd(OFS_ACC, {16'h0, a[15:8], s[7:0]});
    rd(OFS_PS, {16'h0, e});
  endtask

  ////////////////////////////////////////////////////////////////////////
  // watcher: takes the oldest note whenever a result is presented
  always @(posedge hclk) begin
    if (watch_en && hreadyout === 1'b1) begin
      case (watch_sel)
        2'h0: check(hrdata, exp_q.pop_front());
        2'h1: check({16'h0, direct_phys_addr}, exp_q.pop_front());
        2'h2: check({16'h0, gpr_phys_addr}, exp_q.pop_front());
        default: check({31'h0, irq_accept}, exp_q.pop_front());
      endcase
    end
  end

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // watchdog: the whole sequence needs well under 10000 cycles
  initial begin
    #100000;
    num_errors++;
    give_verdict();
  end

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    logic [7:0] dir;
    logic [4:0] rp;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 6; i++) rd(8'(i * 4), 32'h0);
    rd(OFS_PS, {16'h0, PS_RESET});
    rd(OFS_ID, ID_VALUE);
    rd(8'h30, 32'h0);
    port(2'h3, 32'h0);
    $display("test reset values done");
    for (int i = 0; i < 7; i++) begin
      seed = lfsr(seed);
      wr(8'(i * 4), seed);
      rd(8'(i * 4), {16'h0, seed[15:0]});
    end
    wr(8'h34, seed);
    rd(8'h34, 32'h0);
    $display("test readback done");
    for (int op = 0; op < 4; op++) begin
      seed = lfsr(seed);
      alu(3'(op), seed[15:0], seed[31:16]);
    end
    alu(OP_ADD, 16'h5A80, 16'h0080);
    alu(OP_ADD, 16'h007F, 16'h0001);
    alu(OP_SUB, 16'h0010, 16'h0001);
    alu(OP_SUB, 16'h0080, 16'h0001);
    $display("test alu flags done");
    for (int d = 0; d < 8; d++) begin
      for (int k = 0; k < 2; k++) begin
        seed = lfsr(seed);
        dir = {k[0], seed[6:0]};
        wr(OFS_PS, {16'h0, seed[15:11], d[2:0], 8'h30});
        wr(OFS_DIR, {24'h0, dir});
        port(2'h1, (dir[7] && d != 0) ? {16'h0, DIR_MAP_BASE +
          16'((d - 1) * 128) + {9'h0, dir[6:0]}} : {24'h0, dir});
      end
    end
    $display("test direct remap done");
    for (int x = 0; x < 8; x++) begin
      seed = lfsr(seed);
      rp = (x == 7) ? 5'h1F : seed[15:11];
      wr(OFS_PS, {16'h0, rp, seed[2:0], 8'h30});
      wr(OFS_GPR, 32'(x));
      port(2'h2, {16'h0, BANK_BASE + {8'h0, rp, 3'h0} + 16'(x)});
    end
    $display("test register bank done");
    for (int j = 0; j < 64; j++) begin
      wr(OFS_PS, {24'h0, 1'b0, j[5], j[4:3], 4'h0});
      wr(OFS_IRQ, {29'h0, j[0], j[2:1]});
      port(2'h3, {31'h0, j[5] & j[0] & (j[2:1] < j[4:3])});
    end
    $display("test interrupt admit done");
    repeat (3) @(posedge hclk);
    give_verdict();
  end
endmodule // csba_core_test
